// ===== rtl/riv_pkg.sv
/*
 * Package for the reset and interrupt vectoring block: vectors, reset causes,
 * flag layout, stack depth and the carrier structs.
 * Assumes a 12-bit program counter and an 8-bit data path.
 */
package riv_pkg;

    // ------------------------------------------------------------------
    // Widths and vectors
    // ------------------------------------------------------------------
    localparam int           PC_W           = 12;
    localparam int           STACK_DEPTH    = 8;
    localparam int           STACK_PTR_W    = 4;
    localparam int           NUM_IRQ        = 6;
    localparam logic [11:0]  RESET_VECTOR   = 12'h000;
    localparam logic [11:0]  IRQ_VECTOR     = 12'h008;
    localparam logic [3:0]   STACK_PTR_RST  = 4'h0;
    localparam logic [7:0]   ACC_RST        = 8'h00;
    localparam logic [7:0]   FLAG_RST       = 8'h00;

    // ------------------------------------------------------------------
    // Flag register layout
    // ------------------------------------------------------------------
    localparam int           FLAG_CAUSE_A_BIT = 7;
    localparam int           FLAG_CAUSE_B_BIT = 6;
    localparam logic [7:0]   FLAG_CAUSE_MASK  = 8'hc0;

    // ------------------------------------------------------------------
    // Interrupt source positions
    // ------------------------------------------------------------------
    localparam int           IRQ_TIMER0   = 0;
    localparam int           IRQ_TIMER1   = 1;
    localparam int           IRQ_USB      = 2;
    localparam int           IRQ_SERIAL   = 3;
    localparam int           IRQ_WAKE     = 4;
    localparam int           IRQ_EXT      = 5;

    // Edge select codes for the external interrupt line.
    localparam logic [1:0]   EDGE_FALL    = 2'h1;
    localparam logic [1:0]   EDGE_RISE    = 2'h2;
    localparam logic [1:0]   EDGE_BOTH    = 2'h3;

    typedef enum logic [1:0] {
        RIV_CAUSE_POWER,
        RIV_CAUSE_WATCHDOG,
        RIV_CAUSE_PIN
    } riv_cause_t;

    typedef struct packed {
        logic       save;
        logic       restore;
        logic       irq_return;
        logic [7:0] accumulator;
        logic [7:0] flags;
    } riv_cpu_req_t;

    typedef struct packed {
        logic [7:0] accumulator;
        logic [7:0] flags;
    } riv_context_t;

endpackage : riv_pkg

// ===== rtl/riv_stack_mem.sv
/*
 * Return-address store of the vectoring block, one word per level.
 * Assumes one write and one read per cycle; read data are registered.
 */
`timescale 1ns/1ps
`default_nettype none
module riv_stack_mem
    import riv_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int WIDTH = PC_W,
    parameter int AW    = 3
)
(
    input  wire logic             clk_sys,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] mem_reg [DEPTH];

    always_ff @(posedge clk_sys)
    begin
        if (wr_en)
        begin
            mem_reg[wr_addr] <= wr_data;
        end
        rd_data <= mem_reg[rd_addr];
    end

endmodule : riv_stack_mem
`default_nettype wire

// ===== rtl/riv_vector.sv
/*
 * Reset and interrupt vectoring: reset cause flags, program counter redirect,
 * eight-level return stack, six-source interrupt request and one-level
 * context save buffer.
 * Assumes the core steps once per clk_sys cycle and reads pc_out each cycle;
 * reset request pulses and irq sources are synchronous to clk_sys except the
 * port pins and the reset pin, which are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
module riv_vector
    import riv_pkg::*;
#(
    parameter int P0_W = 6,
    parameter int P1_W = 8
)
(
    input  wire logic               clk_sys,
    input  wire logic               rst,
    input  wire logic               power_on_event,
    input  wire logic               watchdog_overflow,
    input  wire logic               reset_pin_mode,
    input  wire logic               reset_shared_input_bit,
    input  wire logic [P0_W-1:0]    port_zero_in,
    input  wire logic [P1_W-1:0]    port_one_in,
    input  wire logic [1:0]         ext_int_edge_select,
    input  wire logic [NUM_IRQ-1:0] irq_enable,
    input  wire logic               timer_zero_irq,
    input  wire logic               second_timer_counter_irq,
    input  wire logic               usb_irq,
    input  wire logic               serial_io_unit_irq,
    input  wire logic               global_irq_enable,
    input  wire logic               irq_ack_clear,
    input  wire logic [NUM_IRQ-1:0] irq_clear,
    input  wire logic [PC_W-1:0]    pc_next_seq,
    input  wire riv_cpu_req_t       cpu_req,
    output logic [PC_W-1:0]         pc_out,
    output riv_context_t            context_out,
    output logic                    reset_cause_flag_a,
    output logic                    reset_cause_flag_b,
    output logic [NUM_IRQ-1:0]      irq_pending,
    output logic                    wakeup_event,
    output logic                    port_bit_reset_shared,
    output logic [STACK_PTR_W-1:0]  stack_level,
    output logic                    stack_overflow
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    localparam int SYN_W = P0_W + P1_W + 1;
    logic [SYN_W-1:0] pin_meta_reg;
    logic [SYN_W-1:0] pin_sync_reg;
    logic [SYN_W-1:0] pin_prev_reg;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            // Pins idle high, so a zero here would look like an edge after reset.
            pin_meta_reg <= '1;
            pin_sync_reg <= '1;
            pin_prev_reg <= '1;
        end
        else
        begin
            pin_meta_reg <= {reset_shared_input_bit, port_one_in, port_zero_in};
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // ------------------------------------------------------------------
    // Wake-up and external edge detect
    // ------------------------------------------------------------------
    wire [SYN_W-1:0] pin_change = pin_sync_reg ^ pin_prev_reg;
    // The shared reset bit only wakes the core while it is a plain input.
    wire       wake_hit   = (|pin_change[P0_W+P1_W-1:0])
                          | (pin_change[SYN_W-1] & ~reset_pin_mode);
    wire       ext_now    = pin_sync_reg[0];
    wire       ext_before = pin_prev_reg[0];
    wire       ext_fall   = ext_before & ~ext_now;
    wire       ext_rise   = ~ext_before & ext_now;
    wire       ext_hit    = (ext_int_edge_select == EDGE_FALL) ? ext_fall
                          : (ext_int_edge_select == EDGE_RISE) ? ext_rise
                          : (ext_int_edge_select == EDGE_BOTH) ? (ext_fall | ext_rise)
                          : ext_fall;

    // ------------------------------------------------------------------
    // Interrupt request flags
    // ------------------------------------------------------------------
    logic [NUM_IRQ-1:0] irq_set;
    assign irq_set[IRQ_TIMER0] = timer_zero_irq;
    assign irq_set[IRQ_TIMER1] = second_timer_counter_irq;
    assign irq_set[IRQ_USB]    = usb_irq;
    assign irq_set[IRQ_SERIAL] = serial_io_unit_irq;
    assign irq_set[IRQ_WAKE]   = wake_hit;
    assign irq_set[IRQ_EXT]    = ext_hit;

    logic [NUM_IRQ-1:0] irq_reg;
    logic               in_service_reg;
    // Set wins over clear so an event in the clearing cycle survives.
    wire [NUM_IRQ-1:0]  irq_next = (irq_reg & ~irq_clear) | irq_set;
    wire                irq_take = global_irq_enable & ~in_service_reg
                                 & (|(irq_reg & irq_enable));

    // ------------------------------------------------------------------
    // Reset cause capture
    // ------------------------------------------------------------------
    logic       pin_rst_sync_reg;
    logic       pin_reset_meta_reg;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pin_reset_meta_reg <= 1'b1;
            pin_rst_sync_reg   <= 1'b1;
        end
        else
        begin
            pin_reset_meta_reg <= reset_shared_input_bit;
            pin_rst_sync_reg   <= pin_reset_meta_reg;
        end
    end
    // Outside keeps the pin high; a low level while in reset mode resets.
    wire pin_reset = reset_pin_mode & ~pin_rst_sync_reg;
    // Priority power-on over pin over watchdog, as one cause must win.
    wire any_reset = power_on_event | pin_reset | watchdog_overflow;
    riv_cause_t cause;
    assign cause = power_on_event ? RIV_CAUSE_POWER
                 : pin_reset      ? RIV_CAUSE_PIN
                 : RIV_CAUSE_WATCHDOG;

    logic cause_a_reg;
    logic cause_b_reg;
    logic cause_a_next;
    logic cause_b_next;
    always_comb
    begin
        cause_a_next = cause_a_reg;
        cause_b_next = cause_b_reg;
        if (any_reset)
        begin
            case (cause)
                RIV_CAUSE_POWER:    begin cause_a_next = 1'b1; cause_b_next = 1'b0; end
                RIV_CAUSE_WATCHDOG: begin cause_a_next = 1'b0; cause_b_next = 1'b0; end
                RIV_CAUSE_PIN:      begin cause_a_next = 1'b1; cause_b_next = 1'b1; end
                default:            begin cause_a_next = 1'b1; cause_b_next = 1'b0; end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Return stack
    // ------------------------------------------------------------------
    logic [STACK_PTR_W-1:0] sp_reg;
    logic                   ovf_reg;
    wire                    do_push = irq_take & ~any_reset;
    wire                    do_pop  = cpu_req.irq_return & ~any_reset & (sp_reg != STACK_PTR_RST);
    wire [2:0]              wr_idx  = sp_reg[2:0];
    wire [2:0]              rd_idx  = 3'(sp_reg - 4'h1);
    wire [PC_W-1:0]         pop_pc;

    riv_stack_mem #(
        .DEPTH (STACK_DEPTH),
        .WIDTH (PC_W),
        .AW    (3)
    ) u_stack (
        .clk_sys (clk_sys),
        .wr_en   (do_push),
        .wr_addr (wr_idx),
        .wr_data (pc_next_seq),
        .rd_addr (rd_idx),
        .rd_data (pop_pc)
    );

    // Registered read data arrive one cycle after the return request.
    logic pop_pend_reg;

    // ------------------------------------------------------------------
    // Context save buffer
    // ------------------------------------------------------------------
    riv_context_t ctx_reg;
    riv_context_t ctx_next;
    always_comb
    begin
        ctx_next = ctx_reg;
        if (cpu_req.save)
        begin
            ctx_next.accumulator = cpu_req.accumulator;
            ctx_next.flags       = cpu_req.flags & ~FLAG_CAUSE_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Sequential state
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cause_a_reg    <= 1'b1;
            cause_b_reg    <= 1'b0;
            irq_reg        <= '0;
            in_service_reg <= 1'b0;
            sp_reg         <= STACK_PTR_RST;
            ovf_reg        <= 1'b0;
            pop_pend_reg   <= 1'b0;
            pc_out         <= RESET_VECTOR;
            ctx_reg        <= '{accumulator: ACC_RST, flags: FLAG_RST};
            context_out    <= '{accumulator: ACC_RST, flags: FLAG_RST};
            wakeup_event   <= 1'b0;
            port_bit_reset_shared <= 1'b0;
        end
        else if (any_reset)
        begin
            cause_a_reg    <= cause_a_next;
            cause_b_reg    <= cause_b_next;
            irq_reg        <= '0;
            in_service_reg <= 1'b0;
            sp_reg         <= STACK_PTR_RST;
            ovf_reg        <= 1'b0;
            pop_pend_reg   <= 1'b0;
            pc_out         <= RESET_VECTOR;
            ctx_reg        <= '{accumulator: ACC_RST, flags: FLAG_RST};
            context_out    <= '{accumulator: ACC_RST, flags: FLAG_RST};
            wakeup_event   <= 1'b0;
            port_bit_reset_shared <= 1'b0;
        end
        else
        begin
            irq_reg      <= irq_next;
            ctx_reg      <= ctx_next;
            wakeup_event <= wake_hit;
            port_bit_reset_shared <= ~reset_pin_mode & pin_sync_reg[SYN_W-1];
            pop_pend_reg <= do_pop;
            if (cpu_req.restore)
            begin
                context_out.accumulator <= ctx_reg.accumulator;
                context_out.flags       <= (ctx_reg.flags & ~FLAG_CAUSE_MASK)
                                         | {cause_a_reg, cause_b_reg, 6'h00};
            end
            if (do_push)
            begin
                sp_reg         <= (sp_reg == 4'(STACK_DEPTH)) ? sp_reg : 4'(sp_reg + 4'h1);
                ovf_reg        <= ovf_reg | (sp_reg == 4'(STACK_DEPTH));
                in_service_reg <= 1'b1;
                pc_out         <= IRQ_VECTOR;
            end
            else if (do_pop)
            begin
                sp_reg         <= 4'(sp_reg - 4'h1);
                in_service_reg <= 1'b0;
            end
            else if (pop_pend_reg)
            begin
                pc_out <= pop_pc;
            end
            else
            begin
                pc_out <= pc_next_seq;
            end
        end
    end

    assign reset_cause_flag_a = cause_a_reg;
    assign reset_cause_flag_b = cause_b_reg;
    assign irq_pending        = irq_reg;
    assign stack_level        = sp_reg;
    assign stack_overflow     = ovf_reg;

endmodule : riv_vector
`default_nettype wire

// ===== bench/riv_monitor.sv
/* Checker for riv_vector: assertions and covers on the top module's ports.
   Assumes it is bound into riv_vector and that clk_sys is the only clock. */
`timescale 1ns/1ps
`default_nettype none
module riv_monitor
    import riv_pkg::*;
#(
    parameter int P0_W = 6,
    parameter int P1_W = 8
)
(
    input wire logic                   clk_sys,
    input wire logic                   rst,
    input wire logic                   power_on_event,
    input wire logic                   watchdog_overflow,
    input wire logic                   reset_pin_mode,
    input wire logic                   reset_shared_input_bit,
    input wire logic [P1_W-1:0]        port_one_in,
    input wire riv_cpu_req_t           cpu_req,
    input wire logic [PC_W-1:0]        pc_out,
    input wire riv_context_t           context_out,
    input wire logic                   reset_cause_flag_a,
    input wire logic                   reset_cause_flag_b,
    input wire logic [NUM_IRQ-1:0]     irq_pending,
    input wire logic                   wakeup_event,
    input wire logic                   port_bit_reset_shared,
    input wire logic [STACK_PTR_W-1:0] stack_level
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic sync_rst;
    assign sync_rst = power_on_event | watchdog_overflow;

    a_por_causes:
    assert property (power_on_event |=> reset_cause_flag_a && !reset_cause_flag_b)
        else $error("power-on cause flags wrong");
    a_wdt_causes:
    assert property (watchdog_overflow && !power_on_event
        && !(reset_pin_mode && !$past(reset_shared_input_bit, 2))
        |=> !reset_cause_flag_a && !reset_cause_flag_b) else $error("watchdog cause flags wrong");
    a_pin_causes:
    assert property ((reset_pin_mode && !reset_shared_input_bit && !power_on_event)[*3]
        |=> reset_cause_flag_a && reset_cause_flag_b) else $error("pin cause flags wrong");
    a_reset_clears:
    assert property (sync_rst |=> pc_out == RESET_VECTOR && stack_level == STACK_PTR_RST
        && irq_pending == '0 && context_out == '0) else $error("reset state wrong");
    a_irq_vector:
    assert property (stack_level > $past(stack_level) |-> pc_out == IRQ_VECTOR)
        else $error("push without jump to vector");
    a_stack_bound:
    assert property (stack_level <= STACK_DEPTH) else $error("stack level above depth");
    a_restore_ctx:
    assert property (cpu_req.save && !sync_rst ##1 cpu_req.restore && !sync_rst
        |=> context_out.accumulator == $past(cpu_req.accumulator, 2)
        && context_out.flags == (($past(cpu_req.flags, 2) & ~FLAG_CAUSE_MASK)
        | {reset_cause_flag_a, reset_cause_flag_b, 6'h00})) else $error("restored context wrong");
    a_return_pops:
    assert property (cpu_req.irq_return && stack_level != 0 && !sync_rst
        |=> stack_level == $past(stack_level) - 1) else $error("return did not pop");
    a_wake_change:
    assert property ($changed(port_one_in) && !sync_rst |-> ##[1:4] wakeup_event)
        else $error("no wake-up after port change");
    a_shared_bit:
    assert property ((!reset_pin_mode && !sync_rst && $stable(reset_shared_input_bit))[*5]
        |-> port_bit_reset_shared == reset_shared_input_bit) else $error("shared bit wrong");

    c_irq_taken: cover property (stack_level > $past(stack_level));
    c_pin_reset: cover property (reset_cause_flag_a && reset_cause_flag_b);
    c_restore: cover property (cpu_req.restore);
endmodule : riv_monitor
bind riv_vector riv_monitor #(.P0_W(P0_W), .P1_W(P1_W)) u_riv_monitor (
    .clk_sys(clk_sys), .rst(rst), .power_on_event(power_on_event), .watchdog_overflow(watchdog_overflow),
    .reset_pin_mode(reset_pin_mode), .reset_shared_input_bit(reset_shared_input_bit),
    .port_one_in(port_one_in), .cpu_req(cpu_req), .pc_out(pc_out), .context_out(context_out),
    .reset_cause_flag_a(reset_cause_flag_a), .reset_cause_flag_b(reset_cause_flag_b),
    .irq_pending(irq_pending), .wakeup_event(wakeup_event),
    .port_bit_reset_shared(port_bit_reset_shared), .stack_level(stack_level));
`default_nettype wire

// ===== bench/riv_periph_model.sv
/* Peripheral model: turns bench requests into one-cycle interrupt pulses.
   Assumes requests last one cycle; they are captured at the rising edge. */
`timescale 1ns/1ps
`default_nettype none
module riv_periph_model
(
    input  wire logic       clk_sys,
    input  wire logic [3:0] fire,
    output logic      [3:0] pulse
);
    // Pulses leave at a falling edge so the core samples them cleanly.
    // Capturing at the rising edge avoids a race with the bench's own falling-edge writes.
    logic [3:0] fire_seen = 4'h0;
    always @(posedge clk_sys) fire_seen <= fire;
    always @(negedge clk_sys) pulse <= fire_seen;
endmodule : riv_periph_model
`default_nettype wire

// ===== bench/tb_top.sv
/* Testbench for riv_vector: resets, vectoring, context buffer, pins.
   Assumes the peripheral model and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import riv_pkg::*;
    logic                   clk_sys;
    logic                   rst;
    logic                   power_on_event;
    logic                   watchdog_overflow;
    logic                   reset_pin_mode;
    logic                   reset_shared_input_bit;
    logic [5:0]             port_zero_in;
    logic [7:0]             port_one_in;
    logic [1:0]             ext_int_edge_select;
    logic [NUM_IRQ-1:0]     irq_enable;
    logic [3:0]             fire;
    logic [3:0]             pulse;
    logic                   global_irq_enable;
    logic [NUM_IRQ-1:0]     irq_clear;
    logic [PC_W-1:0]        pc_next_seq;
    riv_cpu_req_t           cpu_req;
    logic [PC_W-1:0]        pc_out;
    riv_context_t           context_out;
    logic                   reset_cause_flag_a;
    logic                   reset_cause_flag_b;
    logic [NUM_IRQ-1:0]     irq_pending;
    logic [STACK_PTR_W-1:0] stack_level;
    logic                   port_bit_reset_shared;
    logic                   stack_overflow;
    int                     miscompares = 0;
    int                     check_count = 0;
    int                     cycles = 0;

    riv_periph_model u_riv_periph_model (.clk_sys(clk_sys), .fire(fire), .pulse(pulse));
    riv_vector u_riv_vector (.*, .irq_ack_clear(1'b0), .timer_zero_irq(pulse[0]),
        .second_timer_counter_irq(pulse[1]), .usb_irq(pulse[2]), .serial_io_unit_irq(pulse[3]),
        .wakeup_event());

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    task automatic do_reset(input int k);
        power_on_event = (k == 0);
        watchdog_overflow = (k == 1);
        reset_shared_input_bit = (k != 2);
        cyc(3);
        chk("causes", {14'h0, k != 1, k == 2}, {14'h0, reset_cause_flag_a, reset_cause_flag_b});
        chk("pc", {4'h0, RESET_VECTOR}, {4'h0, pc_out});
        chk("stack", 16'h0000, {12'h0, stack_level});
        chk("state", 16'h0000, {10'h0, irq_pending} | context_out);
        power_on_event = 1'b0;
        watchdog_overflow = 1'b0;
        reset_shared_input_bit = 1'b1;
        cyc(4);
    endtask : do_reset
    task automatic take(input int i);
        pc_next_seq = 12'h100 + 12'(i);
        irq_enable = 6'h01 << i;
        if (i < 4)
            fire[i] = 1'b1;
        if (i == 4)
            port_one_in = ~port_one_in;
        if (i == 5)
            port_zero_in[0] = ~port_zero_in[0];
        cyc(1);
        fire = 4'h0;
        repeat (20)
            if (pc_out !== IRQ_VECTOR)
                cyc(1);
        chk("vector", {4'h0, IRQ_VECTOR}, {4'h0, pc_out});
    endtask : take
    task automatic ret_clear;
        irq_enable = '0;
        irq_clear = '1;
        pc_next_seq = 12'h7ff;
        cpu_req.irq_return = 1'b1;
        cyc(1);
        irq_clear = '0;
        cpu_req.irq_return = 1'b0;
        cyc(1);
    endtask : ret_clear

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            test_done();
        end
    end

    initial
    begin
        {rst, power_on_event, watchdog_overflow, fire, irq_enable, irq_clear} = '0;
        {reset_pin_mode, reset_shared_input_bit, global_irq_enable} = 3'h7;
        {port_zero_in, port_one_in, ext_int_edge_select} = {6'h3f, 8'hff, EDGE_BOTH};
        cpu_req = '0;
        pc_next_seq = 12'h7ff;
        rst = 1'b1;
        cyc(5);
        chk("por", 16'h2000, {2'h0, reset_cause_flag_a, reset_cause_flag_b, pc_out});
        rst = 1'b0;
        for (int k = 0; k < 3; k++)
            do_reset(k);
        $display("test resets done");
        for (int i = 0; i < 6; i++)
        begin
            take(i);
            chk("push", 16'h0001, {12'h0, stack_level});
            ret_clear();
            chk("popped", 16'h0100 + 16'(i), {4'h0, pc_out});
        end
        ret_clear();
        chk("empty", 16'h0000, {12'h0, stack_level});
        $display("test vectoring done");
        global_irq_enable = 1'b0;
        for (int c = 0; c < 4; c++)
        begin
            ext_int_edge_select = 2'(c);
            port_zero_in[0] = ~port_zero_in[0];
            cyc(5);
            irq_clear = '1;
            chk("ext_edge", {15'h0, port_zero_in[0] ? c > 1 : c != 2}, {15'h0, irq_pending[IRQ_EXT]});
            cyc(1);
            irq_clear = '0;
        end
        $display("test edges done");
        reset_pin_mode = 1'b0;
        reset_shared_input_bit = 1'b0;
        cyc(6);
        chk("no_reset", 16'h37ff, {2'h0, reset_cause_flag_a, reset_cause_flag_b, pc_out});
        reset_shared_input_bit = 1'b1;
        cyc(4);
        chk("shared_bit", 16'h0001, {15'h0, port_bit_reset_shared});
        reset_pin_mode = 1'b1;
        cpu_req = {3'h4, 16'ha1ff};
        cyc(1);
        cpu_req = {3'h4, 16'hb23c};
        cyc(1);
        cpu_req = {3'h2, 16'h0000};
        cyc(1);
        cpu_req = '0;
        chk("context", 16'hb2fc, context_out);
        $display("test context done");
        global_irq_enable = 1'b1;
        take(0);
        do_reset(1);
        chk("overflow", 16'h0000, {15'h0, stack_overflow});
        $display("test abort done");
        test_done();
    end
endmodule : tb_top
`default_nettype wire
